// ==== core/ncm_axil_slave.sv ====
`timescale 1ns/1ps
// ==========================================
// AXI4-Lite slave front end
module ncm_axil_slave (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_wr_en,
  output logic [31:0] o_wr_addr,
  output logic [31:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  input wire logic i_wr_ok,
  output logic [31:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_ok
);
  logic aw_held;
  logic w_held;
  logic [31:0] addr_q;
  logic [31:0] data_q;
  logic [3:0] strb_q;
  logic [1:0] bresp;
  logic bvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic next_aw_held;
  logic next_w_held;
  logic [31:0] next_addr_q;
  logic [31:0] next_data_q;
  logic [3:0] next_strb_q;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic do_wr;

  // Channel readies and write commit
  assign o_awready = !aw_held && !bvalid;
  assign o_wready = !w_held && !bvalid;
  assign o_arready = !rvalid;
  assign do_wr = aw_held && w_held && !bvalid;

  // Next state for both directions
  always_comb begin
    next_aw_held = do_wr ? 1'b0 : (aw_held | (i_awvalid & o_awready));
    next_w_held = do_wr ? 1'b0 : (w_held | (i_wvalid & o_wready));
    next_addr_q = (i_awvalid & o_awready) ? i_awaddr : addr_q;
    next_data_q = (i_wvalid & o_wready) ? i_wdata : data_q;
    next_strb_q = (i_wvalid & o_wready) ? i_wstrb : strb_q;
    next_bvalid = do_wr | (bvalid & !i_bready);
    next_bresp = do_wr ? (i_wr_ok ? ncm_pkg::RESP_OKAY : ncm_pkg::RESP_SLVERR) : bresp;
    next_rvalid = (i_arvalid & o_arready) | (rvalid & !i_rready);
    next_rdata = (i_arvalid & o_arready) ? i_rd_data : rdata;
    next_rresp = rresp;
    if (i_arvalid & o_arready) begin
      next_rresp = i_rd_ok ? ncm_pkg::RESP_OKAY : ncm_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      strb_q <= '0;
      bvalid <= 1'b0;
      bresp <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      addr_q <= next_addr_q;
      data_q <= next_data_q;
      strb_q <= next_strb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // Outputs toward bus and register file
  assign o_bvalid = bvalid;
  assign o_bresp = bresp;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
  assign o_rresp = rresp;
  assign o_wr_en = do_wr;
  assign o_wr_addr = addr_q;
  assign o_wr_data = data_q;
  assign o_wr_strb = strb_q;
  assign o_rd_addr = i_araddr;
endmodule : ncm_axil_slave

// ==== core/ncm_host_ctrl.sv ====
`timescale 1ns/1ps
module ncm_host_ctrl #(
  parameter int NUM_XCVR = 10,
  parameter int ST_ACT_DL = ncm_pkg::ST_ACT_DL_CYC,
  parameter int ST_DEACT_DL = ncm_pkg::ST_DEACT_DL_CYC,
  parameter int U_DEACT_DL = ncm_pkg::U_DEACT_DL_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [31:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [31:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic [NUM_XCVR-1:0] i_xcvr_active,
  input wire logic i_bus_bit_clock,
  input wire logic i_bus_frame_sync,
  output logic [3:0] o_mux_sel,
  output logic o_local_rate_generator,
  output logic o_net_clock_enable_bit,
  output logic o_net_clock_sel_high,
  output logic o_net_clock_sel_low,
  output logic o_line_ref_enable_bit,
  output logic [NUM_XCVR-1:0] o_line_terminal_act
);
  // ==========================================
  // Declarations
  logic wr_en;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic [NUM_XCVR-1:0] active;
  logic [NUM_XCVR-1:0] rise;
  logic [NUM_XCVR-1:0] fall;
  logic [1:0] bus_lvl;
  logic [1:0] bus_rise;
  logic auto_mode;
  logic [NUM_XCVR-1:0] kind_u;
  logic [3:0] xcfg;
  logic miss;
  logic [3:0] sel;
  logic pend;
  logic [23:0] dl_cnt;
  logic [7:0] rate_cnt;
  logic rate_clk;
  logic [5:0] loss_cnt;
  logic [15:0] frames;
  logic [NUM_XCVR-1:0] lt_act;
  logic next_auto_mode;
  logic [NUM_XCVR-1:0] next_kind_u;
  logic [3:0] next_xcfg;
  logic next_miss;
  logic [3:0] next_sel;
  logic next_pend;
  logic [23:0] next_dl_cnt;
  logic [7:0] next_rate_cnt;
  logic next_rate_clk;
  logic [5:0] next_loss_cnt;
  logic [15:0] next_frames;
  logic [NUM_XCVR-1:0] next_lt_act;
  logic [NUM_XCVR-1:0] master_mask;
  logic [NUM_XCVR-1:0] other;
  logic master_fall;
  logic cur_u;
  logic ev;
  logic [23:0] ev_limit;
  logic clk_present;
  ncm_pkg::ncm_idx_e wr_idx;

  // ==========================================
  // Helper functions
  // Address to register index
  function automatic ncm_pkg::ncm_idx_e reg_index(input logic [31:0] a);
    case (a)
      ncm_pkg::REG_CTRL: reg_index = ncm_pkg::IDX_CTRL;
      ncm_pkg::REG_SEL: reg_index = ncm_pkg::IDX_SEL;
      ncm_pkg::REG_KIND: reg_index = ncm_pkg::IDX_KIND;
      ncm_pkg::REG_STATUS: reg_index = ncm_pkg::IDX_STATUS;
      ncm_pkg::REG_XCFG: reg_index = ncm_pkg::IDX_XCFG;
      ncm_pkg::REG_FRAMES: reg_index = ncm_pkg::IDX_FRAMES;
      default: reg_index = ncm_pkg::IDX_NONE;
    endcase
  endfunction : reg_index

  // Lowest set transceiver as mux code, zero if none
  function automatic logic [3:0] pick(input logic [NUM_XCVR-1:0] m);
    pick = 4'h0;
    for (int i = NUM_XCVR - 1; i >= 0; i--) begin
      if (m[i]) begin
        pick = 4'(i + 1);
      end
    end
  endfunction : pick

  // ==========================================
  // Bus slave and input synchronisers
  ncm_axil_slave u_bus (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_awaddr(i_s_axi_awaddr),
    .i_awvalid(i_s_axi_awvalid),
    .o_awready(o_s_axi_awready),
    .i_wdata(i_s_axi_wdata),
    .i_wstrb(i_s_axi_wstrb),
    .i_wvalid(i_s_axi_wvalid),
    .o_wready(o_s_axi_wready),
    .o_bresp(o_s_axi_bresp),
    .o_bvalid(o_s_axi_bvalid),
    .i_bready(i_s_axi_bready),
    .i_araddr(i_s_axi_araddr),
    .i_arvalid(i_s_axi_arvalid),
    .o_arready(o_s_axi_arready),
    .o_rdata(o_s_axi_rdata),
    .o_rresp(o_s_axi_rresp),
    .o_rvalid(o_s_axi_rvalid),
    .i_rready(i_s_axi_rready),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .i_wr_ok(reg_index(wr_addr) != ncm_pkg::IDX_NONE),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_ok(reg_index(rd_addr) != ncm_pkg::IDX_NONE)
  );

  ncm_sync #(.W(NUM_XCVR)) u_act_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_xcvr_active),
    .o_level(active),
    .o_rise(rise),
    .o_fall(fall)
  );

  ncm_sync #(.W(2)) u_bus_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_bus_frame_sync, i_bus_bit_clock}),
    .o_level(bus_lvl),
    .o_rise(bus_rise),
    .o_fall()
  );

  // ==========================================
  // Master selection policy
  // Current master, same-kind survivors, deadline to arm
  always_comb begin
    master_mask = '0;
    if (sel != 4'h0) begin
      master_mask = NUM_XCVR'(1) << (sel - 4'h1);
    end
    master_fall = |(fall & master_mask);
    cur_u = |(kind_u & master_mask);
    other = active & ~master_mask & (cur_u ? kind_u : ~kind_u);
    ev = 1'b0;
    ev_limit = '0;
    if (master_fall && !cur_u) begin
      ev = 1'b1;
      ev_limit = 24'(ST_DEACT_DL);
    end else if (master_fall && cur_u && (other != '0)) begin
      ev = 1'b1;
      ev_limit = 24'(U_DEACT_DL);
    end else if ((sel == 4'h0) && |(rise & ~kind_u)) begin
      ev = 1'b1;
      ev_limit = 24'(ST_ACT_DL);
    end
  end

  // Mux select, pending switch and its deadline
  always_comb begin
    wr_idx = reg_index(wr_addr);
    next_sel = sel;
    if (auto_mode) begin
      if (master_fall) begin
        if (other != '0) begin
          next_sel = pick(other);
        end else if (!cur_u) begin
          next_sel = 4'h0;
        end
      end else if ((sel == 4'h0) && (rise != '0)) begin
        next_sel = pick(rise);
      end
    end else if (wr_en && wr_strb[0] && (wr_idx == ncm_pkg::IDX_SEL)) begin
      if (wr_data[3:0] <= 4'(NUM_XCVR)) begin
        next_sel = wr_data[3:0];
      end
    end
    next_pend = pend;
    next_dl_cnt = dl_cnt;
    if (next_sel != sel) begin
      next_pend = 1'b0;
    end else if (ev) begin
      next_pend = 1'b1;
      next_dl_cnt = ev_limit;
    end else if (pend && (dl_cnt != '0)) begin
      next_dl_cnt = dl_cnt - 24'h1;
    end
  end

  // Answer the line terminal only once a master is chosen
  always_comb begin
    next_lt_act = active & kind_u & (lt_act | {NUM_XCVR{sel != 4'h0}});
  end

  // ==========================================
  // Software registers
  always_comb begin
    next_auto_mode = auto_mode;
    next_kind_u = kind_u;
    next_xcfg = xcfg;
    next_miss = miss;
    if (wr_en && wr_strb[0]) begin
      case (wr_idx)
        ncm_pkg::IDX_CTRL: next_auto_mode = wr_data[ncm_pkg::CTRL_AUTO_BIT];
        ncm_pkg::IDX_KIND: next_kind_u[7:0] = wr_data[7:0];
        ncm_pkg::IDX_XCFG: next_xcfg = wr_data[3:0];
        default: next_xcfg = xcfg;
      endcase
    end
    if (wr_en && wr_strb[1] && (wr_idx == ncm_pkg::IDX_KIND)) begin
      next_kind_u[NUM_XCVR-1:8] = wr_data[NUM_XCVR-1:8];
    end
    if (wr_en && wr_strb[2] && (wr_idx == ncm_pkg::IDX_STATUS)) begin
      if (wr_data[ncm_pkg::STAT_MISS_BIT]) begin
        next_miss = 1'b0;
      end
    end
    // Deadline overrun; set wins over clear
    if (pend && (dl_cnt == 24'h1) && (next_sel == sel)) begin
      next_miss = 1'b1;
    end
  end

  // ==========================================
  // Local rate clock, bus clock watch, frame count
  always_comb begin
    next_rate_cnt = (rate_cnt == 8'(ncm_pkg::RATE_DIV - 1)) ? 8'h0 : rate_cnt + 8'h1;
    next_rate_clk = (next_rate_cnt < 8'(ncm_pkg::RATE_HIGH));
    next_loss_cnt = loss_cnt;
    if (bus_rise[0]) begin
      next_loss_cnt = 6'h0;
    end else if (loss_cnt != 6'(ncm_pkg::CLK_LOSS_CYC)) begin
      next_loss_cnt = loss_cnt + 6'h1;
    end
    next_frames = frames + {15'h0, bus_rise[1] & bus_lvl[0]};
  end
  assign clk_present = (loss_cnt != 6'(ncm_pkg::CLK_LOSS_CYC));

  // Read data by index
  always_comb begin
    case (reg_index(rd_addr))
      ncm_pkg::IDX_CTRL: rd_data = {31'h0, auto_mode};
      ncm_pkg::IDX_SEL: rd_data = {28'h0, sel};
      ncm_pkg::IDX_KIND: rd_data = 32'(kind_u);
      ncm_pkg::IDX_STATUS: rd_data = 32'(active) | {13'h0, pend, miss, clk_present, 16'h0};
      ncm_pkg::IDX_XCFG: rd_data = {28'h0, xcfg};
      ncm_pkg::IDX_FRAMES: rd_data = {16'h0, frames};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // State registers
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      auto_mode <= ncm_pkg::CTRL_RST;
      kind_u <= '0;
      xcfg <= ncm_pkg::XCFG_RST;
      miss <= 1'b0;
      sel <= 4'h0;
      pend <= 1'b0;
      dl_cnt <= '0;
      rate_cnt <= 8'(ncm_pkg::RATE_DIV - 1); // Wraps on first edge, full first period
      rate_clk <= 1'b0;
      loss_cnt <= '0;
      frames <= '0;
      lt_act <= '0;
    end else begin
      auto_mode <= next_auto_mode;
      kind_u <= next_kind_u;
      xcfg <= next_xcfg;
      miss <= next_miss;
      sel <= next_sel;
      pend <= next_pend;
      dl_cnt <= next_dl_cnt;
      rate_cnt <= next_rate_cnt;
      rate_clk <= next_rate_clk;
      loss_cnt <= next_loss_cnt;
      frames <= next_frames;
      lt_act <= next_lt_act;
    end
  end

  // Pin outputs straight from flops
  assign o_mux_sel = sel;
  assign o_local_rate_generator = rate_clk;
  assign o_net_clock_enable_bit = xcfg[ncm_pkg::XCFG_NET_EN_BIT];
  assign o_net_clock_sel_high = xcfg[ncm_pkg::XCFG_SEL_HI_BIT];
  assign o_net_clock_sel_low = xcfg[ncm_pkg::XCFG_SEL_LO_BIT];
  assign o_line_ref_enable_bit = xcfg[ncm_pkg::XCFG_LREF_BIT];
  assign o_line_terminal_act = lt_act;

  // ==========================================
  // Assertions
  st_act_switch_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    auto_mode && (sel == 4'h0) && (rise != '0) |=> (sel != 4'h0))
    else $error("no switch to activating transceiver");
  st_loss_switch_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    auto_mode && master_fall && !cur_u |=> (sel != $past(sel)))
    else $error("S/T master loss not handled");
  st_loss_local_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    auto_mode && master_fall && !cur_u && (other == '0) |=> (sel == 4'h0))
    else $error("local clock not chosen");
  u_loss_switch_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    auto_mode && master_fall && cur_u && (other != '0) |=> (sel != $past(sel)))
    else $error("U master loss not handled");
  u_keep_sel_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    auto_mode && master_fall && cur_u && (other == '0) |=> $stable(sel))
    else $error("selection changed without U survivor");
  deadline_miss_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    pend && (dl_cnt == 24'h1) && (next_sel == sel) |=> miss)
    else $error("deadline overrun not flagged");
  net_clk_cfg_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> o_net_clock_enable_bit && !o_net_clock_sel_high && o_net_clock_sel_low)
    else $error("network clock not set to 2.048 MHz");
  line_ref_cfg_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $past(i_sys_rst) |-> o_line_ref_enable_bit)
    else $error("line reference not enabled");
  rate_period_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(rate_clk) |-> ##61 $rose(rate_clk))
    else $error("local rate period wrong");
  lt_after_sel_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    |(lt_act & ~$past(lt_act)) |-> ($past(sel) != 4'h0))
    else $error("terminal answered before selection");
endmodule : ncm_host_ctrl

// ==== core/ncm_pkg.sv ====
// ==========================================
// Shared constants of the clock master controller
package ncm_pkg;
  // Core clock rate
  localparam int CORE_CLK_KHZ = 125000;
  // Local rate generator target and divider
  localparam int LOCAL_RATE_KHZ = 2048;
  localparam int RATE_DIV = CORE_CLK_KHZ / LOCAL_RATE_KHZ;
  localparam int RATE_HIGH = RATE_DIV / 2;
  // Switch deadlines in ns, counts rounded down
  localparam int ST_ACT_DL_NS = 750000;
  localparam int ST_DEACT_DL_NS = 72800;
  localparam int U_DEACT_DL_NS = 12000000;
  localparam int ST_ACT_DL_CYC = ST_ACT_DL_NS / 1000 * CORE_CLK_KHZ / 1000;
  localparam int ST_DEACT_DL_CYC = ST_DEACT_DL_NS * (CORE_CLK_KHZ / 1000) / 1000;
  localparam int U_DEACT_DL_CYC = U_DEACT_DL_NS / 1000 * CORE_CLK_KHZ / 1000;
  // Bus bit clock loss timeout in core cycles
  localparam int CLK_LOSS_CYC = 40;
  // Register offsets
  localparam logic [31:0] REG_CTRL = 32'h0000_0000;
  localparam logic [31:0] REG_SEL = 32'h0000_0004;
  localparam logic [31:0] REG_KIND = 32'h0000_0008;
  localparam logic [31:0] REG_STATUS = 32'h0000_000c;
  localparam logic [31:0] REG_XCFG = 32'h0000_0010;
  localparam logic [31:0] REG_FRAMES = 32'h0000_0014;
  // Field positions
  localparam int CTRL_AUTO_BIT = 0;
  localparam int STAT_PRESENT_BIT = 16;
  localparam int STAT_MISS_BIT = 17;
  localparam int STAT_PEND_BIT = 18;
  localparam int XCFG_NET_EN_BIT = 0;
  localparam int XCFG_SEL_HI_BIT = 1;
  localparam int XCFG_SEL_LO_BIT = 2;
  localparam int XCFG_LREF_BIT = 3;
  // Values after reset
  localparam logic CTRL_RST = 1'h1;
  localparam logic [3:0] XCFG_RST = 4'hd;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register index decode
  typedef enum {IDX_NONE, IDX_CTRL, IDX_SEL, IDX_KIND, IDX_STATUS, IDX_XCFG, IDX_FRAMES} ncm_idx_e;
endpackage : ncm_pkg

// ==== core/ncm_sync.sv ====
`timescale 1ns/1ps
// ==========================================
// Two flop synchroniser with edge detect
module ncm_sync #(
  parameter int W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_stable;
  logic [W-1:0] next_prev;

  // Shift chain; only stable and prev feed logic
  always_comb begin
    next_meta = i_async;
    next_stable = meta;
    next_prev = stable;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
    end
  end

  // Edges from the settled stages
  assign o_level = stable;
  assign o_rise = stable & ~prev;
  assign o_fall = ~stable & prev;
endmodule : ncm_sync

// ==== verif/ncm_glue_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Glue logic and transceiver clocks at the far side
module ncm_glue_model (
  input wire logic [3:0] i_mux_sel,
  input wire logic i_local_rate_generator,
  input wire logic i_xcvr_clk,
  input wire logic [9:0] i_xcvr_active,
  input wire logic [9:0] i_kind,
  input wire logic i_st_ok,
  input wire logic i_lref_en,
  output logic o_bus_bit_clock,
  output logic o_bus_frame_sync
);
  logic [3:0] last_sel = 4'h0;
  logic [7:0] div = 8'h00;
  logic run;
  // Chosen source runs: U while enabled, S/T only when active at 2.048 MHz
  always_comb begin
    run = 1'b0;
    if (i_mux_sel != 4'h0 && i_mux_sel <= 4'ha) begin
      if (i_kind[i_mux_sel - 4'h1]) run = i_lref_en;
      else run = i_st_ok & i_xcvr_active[i_mux_sel - 4'h1];
    end
  end
  // Stopped clock stays low
  assign o_bus_bit_clock = (i_mux_sel == 4'h0) ? i_local_rate_generator : run & i_xcvr_clk;
  // Divide by 256, restarted on a source switch
  always @(posedge o_bus_bit_clock) begin
    last_sel <= i_mux_sel;
    div <= (i_mux_sel != last_sel) ? 8'h00 : div + 8'h01;
  end
  // Sync pulse one bit period wide
  assign o_bus_frame_sync = (div == 8'h00);
endmodule : ncm_glue_model

// ==== verif/test_net_clock_master_select.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", n, e, g); mismatches++; end end
module test_net_clock_master_select;
  logic i_core_clk = 0, i_sys_rst = 1, xclk = 0;
  logic [31:0] i_s_axi_awaddr = 0, i_s_axi_wdata = 0, i_s_axi_araddr = 0;
  logic [3:0] i_s_axi_wstrb = 0, o_mux_sel;
  logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
  logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
  logic [9:0] i_xcvr_active = 0, o_line_terminal_act, mact = 0, mkind = 0, mlt = 0;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rsp;
  logic [31:0] o_s_axi_rdata, rd, f0, seed = 32'h0000_8fe3;
  logic i_bus_bit_clock, i_bus_frame_sync, o_local_rate_generator;
  logic o_net_clock_enable_bit, o_net_clock_sel_high, o_net_clock_sel_low, o_line_ref_enable_bit;
  int mismatches = 0, tests_run = 0, cyc = 0, msel = 0;
  real tr = 0;
  // ==========================================
  // Clocks and timeout
  initial begin forever #4 i_core_clk = ~i_core_clk; end
  initial begin #3.3; forever #80 xclk = ~xclk; end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin mismatches++; report_and_stop(); end
  end
  // Rate clock period in core cycles
  always @(posedge o_local_rate_generator) begin
    if (tr != 0) `CHK("rate period", 61, int'(($realtime - tr) / 8))
    tr = $realtime;
  end
  // ==========================================
  // Design and far side
  ncm_host_ctrl #(.ST_ACT_DL(200), .ST_DEACT_DL(50), .U_DEACT_DL(300)) DUT (
    .i_core_clk, .i_sys_rst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
    .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_xcvr_active,
    .i_bus_bit_clock, .i_bus_frame_sync, .o_mux_sel, .o_local_rate_generator,
    .o_net_clock_enable_bit, .o_net_clock_sel_high, .o_net_clock_sel_low,
    .o_line_ref_enable_bit, .o_line_terminal_act);
  ncm_glue_model GLUE (.i_mux_sel(o_mux_sel), .i_local_rate_generator(o_local_rate_generator),
    .i_xcvr_clk(xclk), .i_xcvr_active(i_xcvr_active), .i_kind(mkind),
    .i_st_ok(o_net_clock_enable_bit & ~o_net_clock_sel_high & o_net_clock_sel_low),
    .i_lref_en(o_line_ref_enable_bit), .o_bus_bit_clock(i_bus_bit_clock),
    .o_bus_frame_sync(i_bus_frame_sync));
  // ==========================================
  // Bus tasks and reference model
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge i_core_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1;
    i_s_axi_wvalid <= 1;
    i_s_axi_bready <= 1;
    fork
      begin @(posedge i_core_clk iff o_s_axi_awready); i_s_axi_awvalid <= 0; end
      begin @(posedge i_core_clk iff o_s_axi_wready); i_s_axi_wvalid <= 0; end
    join
    @(posedge i_core_clk iff o_s_axi_bvalid);
    rsp = o_s_axi_bresp;
    i_s_axi_bready <= 0;
  endtask : wr
  task automatic rdr(input logic [31:0] a);
    @(posedge i_core_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1;
    i_s_axi_rready <= 1;
    @(posedge i_core_clk iff o_s_axi_arready);
    i_s_axi_arvalid <= 0;
    @(posedge i_core_clk iff o_s_axi_rvalid);
    rd = o_s_axi_rdata;
    rsp = o_s_axi_rresp;
    i_s_axi_rready <= 0;
  endtask : rdr
  // Toggle one activation and predict the selection
  task automatic flip(input int i, input logic au);
    int k;
    logic up;
    up = !mact[i];
    mact[i] = up;
    i_xcvr_active <= mact;
    if (au && up && msel == 0) msel = i + 1;
    else if (au && !up && msel == i + 1) begin
      k = -1;
      for (int j = 9; j >= 0; j--) if (mact[j] && mkind[j] == mkind[i] && j != i) k = j;
      if (k >= 0) msel = k + 1;
      else if (!mkind[i]) msel = 0;
    end
    repeat (8) @(posedge i_core_clk);
    mlt = mact & mkind & (mlt | {10{msel != 0}});
    `CHK("mux sel", msel[3:0], o_mux_sel)
    `CHK("terminal act", mlt, o_line_terminal_act)
  endtask : flip
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 0;
    rdr(ncm_pkg::REG_CTRL);
    `CHK("ctrl reset", 32'h0000_0001, rd)
    `CHK("cfg pins", 4'hd, {o_line_ref_enable_bit, o_net_clock_sel_low,
      o_net_clock_sel_high, o_net_clock_enable_bit})
    rdr(32'h0000_0040);
    `CHK("unmapped read", 2'h2, rsp)
    wr(32'h0000_0040, 32'h0000_0001, 4'hf);
    `CHK("unmapped write", 2'h2, rsp)
    for (int v = 15; v >= 0; v--) begin
      wr(ncm_pkg::REG_XCFG, v, 4'h1);
      rdr(ncm_pkg::REG_XCFG);
      `CHK("xcfg", v[3:0], rd[3:0])
      `CHK("xcfg pins", v[3:0], {o_line_ref_enable_bit, o_net_clock_sel_low,
        o_net_clock_sel_high, o_net_clock_enable_bit})
    end
    wr(ncm_pkg::REG_XCFG, 32'h0000_000d, 4'h1);
    rd = xs();
    mkind = {1'b1, rd[8:1], 1'b0};
    wr(ncm_pkg::REG_KIND, {22'h0, mkind}, 4'h3);
    rdr(ncm_pkg::REG_KIND);
    `CHK("kind", mkind, rd[9:0])
    repeat (60) begin
      rd = xs();
      flip(int'(rd % 32'd10), 1'b1);
    end
    rdr(ncm_pkg::REG_STATUS);
    `CHK("active", mact, rd[9:0])
    `CHK("no miss", 1'b0, rd[17])
    wr(ncm_pkg::REG_CTRL, 32'h0, 4'h1);
    for (int j = 0; j < 10; j++) if (mact[j]) flip(j, 1'b0);
    wr(ncm_pkg::REG_SEL, 32'h0, 4'h1);
    wr(ncm_pkg::REG_SEL, 32'h0000_000b, 4'h1);
    wr(ncm_pkg::REG_STATUS, 32'h0002_0000, 4'h4);
    msel = 0;
    rdr(ncm_pkg::REG_SEL);
    `CHK("sel refused", 4'h0, rd[3:0])
    flip(0, 1'b0);
    repeat (250) @(posedge i_core_clk);
    rdr(ncm_pkg::REG_STATUS);
    `CHK("miss set", 1'b1, rd[17])
    wr(ncm_pkg::REG_SEL, 32'h0000_0001, 4'h1);
    wr(ncm_pkg::REG_STATUS, 32'h0002_0000, 4'h4);
    rdr(ncm_pkg::REG_STATUS);
    `CHK("miss clear", 1'b0, rd[17])
    `CHK("manual sel", 4'h1, o_mux_sel)
    wr(ncm_pkg::REG_SEL, 32'h0000_000a, 4'h1);
    repeat (50) @(posedge i_core_clk);
    rdr(ncm_pkg::REG_FRAMES);
    f0 = rd;
    // Sampling edges exactly two frames apart: 10240 cycles less the read overhead
    repeat (10237) @(posedge i_core_clk);
    rdr(ncm_pkg::REG_FRAMES);
    `CHK("frames", f0 + 32'h2, rd)
    rdr(ncm_pkg::REG_STATUS);
    `CHK("clock present", 1'b1, rd[16])
    report_and_stop();
  end
endmodule : test_net_clock_master_select
